// ==== spsd_pkg.sv ====
// spsd_pkg: register map, field positions, reset values, timing counts
// and shared types of the spi status, data and select block.
// assumes a single 10 mhz system clock and 8-bit special function registers.
package spsd_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hf3;
   localparam logic [7:0] STATUS_ADDR = 8'hf4;
   localparam logic [7:0] DATA_ADDR = 8'hf5;
   localparam logic [7:0] IRQEN_ADDR = 8'hf6;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_SELECT_OUTPUT_ENABLE_BIT = 7;
   localparam int CTRL_EN_BIT = 6;
   localparam int CTRL_CMODE_BIT = 4;
   localparam int ST_DONE_BIT = 7;
   localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
   localparam int ST_OVF_BIT = 5;
   localparam int ST_MODE_FAULT_FLAG_BIT = 4;
   localparam int ST_DIS_BIT = 3;
   localparam int IRQ_PORT_BIT = 0;
   localparam int IRQ_GLOBAL_BIT = 1;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] IRQEN_RESET = 8'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYCLES =
      (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : SCLK_HALF_NS / CLK_PERIOD_NS;
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss_n;
   } spsd_pin_in_s;

   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
      logic ss_n;
      logic ss_oe;
   } spsd_pin_out_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b100
   } spsd_state_e;

endpackage : spsd_pkg

// ==== spsd_sync.sv ====
// spsd_sync: two flip-flop synchroniser for a group of pin levels.
// assumes the inputs are levels from outside the i_clock domain.
`timescale 1ns/1ps
`default_nettype none
module spsd_sync #(
   parameter int WIDTH = 4
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta;

   // first stage is read only by the second stage
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule : spsd_sync
`default_nettype wire

// ==== spsd_shift.sv ====
// spsd_shift: byte shift register, parallel load, msb-first shift in.
// assumes load and shift never come in the same cycle; load wins if so.
`timescale 1ns/1ps
`default_nettype none
module spsd_shift #(
   parameter int WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_load_data,
   input wire logic i_shift,
   input wire logic i_bit,
   output logic [WIDTH-1:0] o_data
);
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_data <= '0;
      end else if (i_load) begin
         o_data <= i_load_data;
      end else if (i_shift) begin
         o_data <= {o_data[WIDTH-2:0], i_bit};
      end
   end
endmodule : spsd_shift
`default_nettype wire

// ==== spsd_core.sv ====
// spsd_core: status flags, data register, select pin and a minimal byte
// engine of an 8-bit spi port, with a plain register port for software.
// assumes pins arrive unsynchronised; the bench link clock is far slower
// than i_clock, so edges of the sampled clock are seen reliably.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - controller mode, fault detection on: select pin is a fault input
// RULE2 - fault detection off: select output enable picks gpio or auto select
// RULE3 - target mode: select pin is always the target select input
// RULE4 - fault detection disable bit only matters in controller mode
// RULE5 - transfer done flag sets on byte complete or receive buffer load
// RULE6 - data register writes are blocked while transfer done is set
// RULE7 - write collision flag sets on each write collision
// RULE8 - overrun flag sets on each overrun
// RULE9 - controller, detection on, select pulled low: mode fault flag sets
// RULE10 - interrupt while done, overrun or fault flag set and both enables on
// RULE11 - hardware never clears the four flags; only software does
// RULE12 - data register write loads the shift register directly
// RULE13 - data register read returns the receive buffer
// RULE14 - controller mode: data write starts one byte exchange
// RULE15 - status register resets to zero
// RULE16 - data register resets to zero
// RULE17 - mode fault clears controller mode and port enable
// RULE18 - write during transfer: byte finishes, new data discarded
// RULE19 - auto select output low during transfer, high when idle
// RULE20 - target software reads data, clears done before next byte
// RULE21 - reserved status bits read zero, writes ignored
module spsd_core
   import spsd_pkg::*;
#(
   parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire spsd_pkg::spsd_pin_in_s i_pins,
   output var spsd_pkg::spsd_pin_out_s o_pins,
   output logic o_irq
);
   import spsd_pkg::*;

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
   localparam int DONE_MAX = 2 * BYTE_BITS * HALF_CYCLES + 4;

   // ---------------------------------------------------------------
   // pin synchronisers and state
   // ---------------------------------------------------------------
   spsd_pin_in_s pin_s;
   logic select_output_enable, port_en, ctrl_mode, dis;
   logic done, write_collision_flag, ovf, mode_fault_flag;
   logic irq_port, irq_glb;
   logic [7:0] rxbuf;
   logic [7:0] shift_q;
   spsd_state_e state;
   logic [7:0] half_cnt;
   logic [2:0] bit_cnt, t_cnt;
   logic cap, t_cap, sclk_prev;

   spsd_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_d(i_pins),
      .o_q(pin_s)
   );

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic wr_ctrl, wr_status, wr_data, wr_irqen;
   logic cmode_act, fault_watch, fault, auto_ss, tgt_sel, c_busy, busy;
   logic wr_ok, wr_col, c_start, t_load;
   logic c_rise, c_fall, c_last, t_rise, t_fall, t_last;
   logic byte_done, do_shift, shift_bit;

   assign wr_ctrl = i_wr && (i_addr == CTRL_ADDR);
   assign wr_status = i_wr && (i_addr == STATUS_ADDR);
   assign wr_data = i_wr && (i_addr == DATA_ADDR);
   assign wr_irqen = i_wr && (i_addr == IRQEN_ADDR);

   assign cmode_act = ctrl_mode && port_en;
   assign fault_watch = ctrl_mode && !dis; // RULE1 RULE4
   assign fault = fault_watch && !pin_s.ss_n; // RULE9
   assign auto_ss = ctrl_mode && dis && select_output_enable; // RULE2 RULE4
   assign tgt_sel = !ctrl_mode && port_en && !pin_s.ss_n; // RULE3
   assign c_busy = (state != ST_IDLE);
   assign busy = c_busy || tgt_sel;

   // a write while done is set is dropped without a collision flag
   assign wr_ok = wr_data && !done && !busy; // RULE6
   assign wr_col = wr_data && !done && busy; // RULE18
   assign c_start = wr_ok && cmode_act && !fault; // RULE14
   assign t_load = wr_ok && !c_start;

   assign c_rise = (state == ST_LOW) && (half_cnt == HALF_LAST);
   assign c_fall = (state == ST_HIGH) && (half_cnt == HALF_LAST);
   assign c_last = c_fall && (bit_cnt == BIT_LAST);
   assign t_rise = tgt_sel && pin_s.sclk && !sclk_prev;
   assign t_fall = tgt_sel && !pin_s.sclk && sclk_prev;
   assign t_last = t_fall && (t_cnt == BIT_LAST);
   assign byte_done = c_last || t_last;
   assign do_shift = c_fall || t_fall;
   assign shift_bit = c_fall ? cap : t_cap;

   // data register writes go straight into the shifter
   spsd_shift #(
      .WIDTH(BYTE_BITS)
   ) u_shift (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_load(wr_ok), // RULE12
      .i_load_data(i_wdata),
      .i_shift(do_shift),
      .i_bit(shift_bit),
      .o_data(shift_q)
   );

   // ---------------------------------------------------------------
   // control and enable registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         select_output_enable <= CTRL_RESET[CTRL_SELECT_OUTPUT_ENABLE_BIT];
         port_en <= CTRL_RESET[CTRL_EN_BIT];
         ctrl_mode <= CTRL_RESET[CTRL_CMODE_BIT];
      end else begin
         if (wr_ctrl) begin
            select_output_enable <= i_wdata[CTRL_SELECT_OUTPUT_ENABLE_BIT];
            port_en <= i_wdata[CTRL_EN_BIT];
            ctrl_mode <= i_wdata[CTRL_CMODE_BIT];
         end
         // hardware disable wins over a software write
         if (fault) begin
            ctrl_mode <= 1'b0; // RULE17
            port_en <= 1'b0; // RULE17
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         irq_port <= IRQEN_RESET[IRQ_PORT_BIT];
         irq_glb <= IRQEN_RESET[IRQ_GLOBAL_BIT];
      end else if (wr_irqen) begin
         irq_port <= i_wdata[IRQ_PORT_BIT];
         irq_glb <= i_wdata[IRQ_GLOBAL_BIT];
      end
   end

   // ---------------------------------------------------------------
   // status flags: software clears by writing zero, set wins
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         done <= STATUS_RESET[ST_DONE_BIT]; // RULE15
         write_collision_flag <= STATUS_RESET[ST_WRITE_COLLISION_FLAG_BIT];
         ovf <= STATUS_RESET[ST_OVF_BIT];
         mode_fault_flag <= STATUS_RESET[ST_MODE_FAULT_FLAG_BIT];
         dis <= STATUS_RESET[ST_DIS_BIT];
      end else begin
         if (wr_status) begin
            done <= done && i_wdata[ST_DONE_BIT]; // RULE11
            write_collision_flag <= write_collision_flag && i_wdata[ST_WRITE_COLLISION_FLAG_BIT];
            ovf <= ovf && i_wdata[ST_OVF_BIT];
            mode_fault_flag <= mode_fault_flag && i_wdata[ST_MODE_FAULT_FLAG_BIT];
            dis <= i_wdata[ST_DIS_BIT];
         end
         if (byte_done) begin
            done <= 1'b1; // RULE5
         end
         if (wr_col) begin
            write_collision_flag <= 1'b1; // RULE7
         end
         if (t_last && done) begin
            ovf <= 1'b1; // RULE8
         end
         if (fault) begin
            mode_fault_flag <= 1'b1; // RULE9
         end
      end
   end

   // an overrun keeps the unread byte and loses the new one
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rxbuf <= DATA_RESET; // RULE16
      end else if (byte_done && !done) begin
         rxbuf <= {shift_q[6:0], shift_bit}; // RULE5
      end
   end

   // ---------------------------------------------------------------
   // controller engine, mode 0, msb first
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= ST_IDLE;
         half_cnt <= 8'h00;
         bit_cnt <= 3'h0;
         cap <= 1'b0;
      end else if (!cmode_act || fault) begin
         state <= ST_IDLE;
         half_cnt <= 8'h00;
         bit_cnt <= 3'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               half_cnt <= 8'h00;
               bit_cnt <= 3'h0;
               if (c_start) begin
                  state <= ST_LOW; // RULE14
               end
            end
            ST_LOW: begin
               half_cnt <= c_rise ? 8'h00 : half_cnt + 8'h01;
               if (c_rise) begin
                  cap <= pin_s.miso;
                  state <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               half_cnt <= c_fall ? 8'h00 : half_cnt + 8'h01;
               if (c_fall) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  state <= c_last ? ST_IDLE : ST_LOW;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // target engine on the sampled link clock
   // ---------------------------------------------------------------
   // select high aborts a partial byte, as the select falling edge starts one
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_prev <= 1'b0;
         t_cnt <= 3'h0;
         t_cap <= 1'b0;
      end else begin
         sclk_prev <= pin_s.sclk;
         if (!tgt_sel) begin
            t_cnt <= 3'h0;
         end else begin
            if (t_rise) begin
               t_cap <= pin_s.mosi;
            end
            if (t_fall) begin
               t_cnt <= t_cnt + 3'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pins, interrupt and read port
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pins <= '0;
         o_pins.ss_n <= 1'b1;
      end else begin
         o_pins.sclk <= (state == ST_HIGH);
         o_pins.sclk_oe <= cmode_act;
         o_pins.mosi <= shift_q[7];
         o_pins.mosi_oe <= cmode_act;
         o_pins.miso <= shift_q[7];
         o_pins.miso_oe <= tgt_sel; // RULE3
         o_pins.ss_n <= !c_busy; // RULE19
         o_pins.ss_oe <= auto_ss; // RULE1 RULE2
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_port && irq_glb && (done || ovf || mode_fault_flag); // RULE10
      end
   end

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (i_addr)
         CTRL_ADDR: begin
            rd_mux[CTRL_SELECT_OUTPUT_ENABLE_BIT] = select_output_enable;
            rd_mux[CTRL_EN_BIT] = port_en;
            rd_mux[CTRL_CMODE_BIT] = ctrl_mode;
         end
         STATUS_ADDR: begin
            rd_mux[ST_DONE_BIT] = done;
            rd_mux[ST_WRITE_COLLISION_FLAG_BIT] = write_collision_flag;
            rd_mux[ST_OVF_BIT] = ovf;
            rd_mux[ST_MODE_FAULT_FLAG_BIT] = mode_fault_flag;
            rd_mux[ST_DIS_BIT] = dis; // RULE21
         end
         DATA_ADDR: begin
            rd_mux = rxbuf; // RULE13
         end
         IRQEN_ADDR: begin
            rd_mux[IRQ_PORT_BIT] = irq_port;
            rd_mux[IRQ_GLOBAL_BIT] = irq_glb;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rd_mux : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_start;
      c_start ##1 (state == ST_LOW);
   endsequence

   sequence s_clear_done;
      wr_status && !i_wdata[ST_DONE_BIT];
   endsequence

   property p_complete;
      s_start |-> ##[1:DONE_MAX] done;
   endproperty

   done_sticky_a: assert property (done && !s_clear_done |=> done) // RULE11
      else $error("transfer done flag dropped without software clear");
   // a dropped write may land on a shift edge, so the shifter may still move
   write_block_a: assert property ( // RULE6
      wr_data && done |=> shift_q == ($past(do_shift) ?
      {$past(shift_q[6:0]), $past(shift_bit)} : $past(shift_q)))
      else $error("data write accepted while transfer done set");
   collision_a: assert property ( // RULE7
      wr_data && !done && busy |=> write_collision_flag && shift_q == ($past(do_shift) ?
      {$past(shift_q[6:0]), $past(shift_bit)} : $past(shift_q)))
      else $error("collision not flagged or data not discarded");
   fault_set_a: assert property (fault |=> mode_fault_flag && !ctrl_mode && !port_en) // RULE9
      else $error("mode fault not flagged or port left enabled");
   irq_out_a: assert property (##1 o_irq == $past(irq_port && irq_glb && (done || ovf || mode_fault_flag))) // RULE10
      else $error("interrupt request does not follow flags and enables");
   load_direct_a: assert property (c_start |=> shift_q == $past(i_wdata) && state == ST_LOW) // RULE12
      else $error("data write did not load shifter and start exchange");
   byte_time_a: assert property (p_complete) // RULE5
      else $error("controller byte did not complete in time");
   read_data_a: assert property (i_rd && i_addr == DATA_ADDR |=> o_rdata == $past(rxbuf)) // RULE13
      else $error("data read did not return receive buffer");
   reserved_a: assert property (i_rd && i_addr == STATUS_ADDR |=> o_rdata[2:0] == 3'h0) // RULE21
      else $error("reserved status bits read nonzero");
   auto_select_a: assert property (auto_ss && c_busy |=> o_pins.ss_oe && !o_pins.ss_n) // RULE19
      else $error("auto select not driven low during transfer");
   overrun_a: assert property (t_last && done |=> ovf && rxbuf == $past(rxbuf)) // RULE8
      else $error("overrun not flagged or buffer overwritten");
endmodule : spsd_core
`default_nettype wire

// ==== spsd_peer.sv ====
// spsd_peer: behavioural far-side spi party, target or controller, mode 0.
// assumes the bench resolves every pin and feeds the wire levels back here.
`timescale 1ns/1ps
`default_nettype none
module spsd_peer (
   input wire logic i_clock,
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_ss_n,
   input wire logic [7:0] i_tx,
   output logic [7:0] o_rx,
   output logic o_sclk,
   output logic o_mosi,
   output logic o_miso,
   output logic o_ss_n
);
   logic act = 1'b0;
   logic m = 1'b0;
   logic tog = 1'b0;
   logic [7:0] tsh = 8'h00;
   // ----------------------------------------------------------
   // target role
   // ----------------------------------------------------------
   // released data lines wander so a stale bit never passes for data
   always @(posedge i_clock) tog <= ~tog;
   assign o_mosi = act ? m : tog;
   assign o_miso = (!i_ss_n && !act) ? tsh[7] : tog;
   initial begin
      o_sclk = 1'b0;
      o_ss_n = 1'b1;
      o_rx = 8'h00;
   end
   always @(negedge i_ss_n) if (!act) tsh = i_tx;
   always @(posedge i_sclk) if (!i_ss_n && !act) o_rx = {o_rx[6:0], i_mosi};
   always @(negedge i_sclk) if (!i_ss_n && !act) tsh = {tsh[6:0], 1'b0};
   // ----------------------------------------------------------
   // controller role, link clock still outside frames
   // ----------------------------------------------------------
   task automatic select(input logic lvl);
      o_ss_n = lvl;
   endtask : select
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      act = 1'b1;
      o_ss_n = 1'b0;
      #400;
      for (int i = 7; i >= 0; i--) begin
         m = tx[i];
         #400 o_sclk = 1'b1;
         rx = {rx[6:0], i_miso};
         #400 o_sclk = 1'b0;
      end
      #400 o_ss_n = 1'b1;
      act = 1'b0;
   endtask : xfer
endmodule : spsd_peer
`default_nettype wire

// ==== tb_spi_status_data_select.sv ====
// tb_spi_status_data_select: register-level tests of spsd_core.
// assumes spsd_peer stands on the pins; ss pulled up, sclk pulled down.
`timescale 1ns/1ps
`default_nettype none
module tb_spi_status_data_select;
   import spsd_pkg::*;
   logic clock, rst, wr, rd, irq;
   logic [7:0] addr, wdata, rdata, tx, got, pr_rx;
   logic pr_sclk, pr_mosi, pr_miso, pr_ss;
   logic sclk_w, mosi_w, miso_w, ss_w;
   spsd_pin_in_s pin_in;
   spsd_pin_out_s po;
   int n_fail = 0;
   int compares = 0;
   // ----------------------------------------------------------
   // pins and instances
   // ----------------------------------------------------------
   assign sclk_w = po.sclk_oe ? po.sclk : pr_sclk;
   assign mosi_w = po.mosi_oe ? po.mosi : pr_mosi;
   assign miso_w = po.miso_oe ? po.miso : pr_miso;
   assign ss_w = po.ss_oe ? po.ss_n : pr_ss;
   assign pin_in = {sclk_w, mosi_w, miso_w, ss_w};
   spsd_core i_dut (.i_clock(clock), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_pins(pin_in), .o_pins(po), .o_irq(irq));
   spsd_peer i_peer (.i_clock(clock), .i_sclk(sclk_w), .i_mosi(mosi_w),
      .i_miso(miso_w), .i_ss_n(ss_w), .i_tx(tx), .o_rx(pr_rx),
      .o_sclk(pr_sclk), .o_mosi(pr_mosi), .o_miso(pr_miso), .o_ss_n(pr_ss));
   always #50 clock = ~clock;
   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #50 chk(rdata, e);
   endtask : rd_chk
   task automatic wirq;
      int k;
      for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clock);
      compares++;
      if (irq !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t no interrupt in time", $time);
         results();
      end
   endtask : wirq
   task automatic sxfer(input logic [7:0] d);
      @(posedge clock);
      #37 i_peer.xfer(d, got);
   endtask : sxfer
   task automatic results;
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   initial begin
      #3000000;
      n_fail++;
      results();
   end
   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {addr, wdata, wr, rd} = '0;
      tx = 8'h3c;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd_chk(STATUS_ADDR, STATUS_RESET);
      rd_chk(DATA_ADDR, DATA_RESET);
      rd_chk(8'h10, 8'h00);
      wr_reg(STATUS_ADDR, 8'h07);
      rd_chk(STATUS_ADDR, 8'h00);
      $display("test reset done");
      wr_reg(STATUS_ADDR, 8'h08);
      wr_reg(CTRL_ADDR, 8'hd0);
      wr_reg(IRQEN_ADDR, 8'h03);
      rd_chk(IRQEN_ADDR, 8'h03);
      chk({6'h00, po.ss_oe, po.ss_n}, 8'h03);
      wr_reg(DATA_ADDR, 8'ha5);
      cyc(4);
      chk({6'h00, po.ss_oe, po.ss_n}, 8'h02);
      wirq();
      chk(pr_rx, 8'ha5);
      rd_chk(DATA_ADDR, 8'h3c);
      rd_chk(STATUS_ADDR, 8'h88);
      chk({6'h00, po.ss_oe, po.ss_n}, 8'h03);
      // done still set: this write must be dropped without a collision
      wr_reg(DATA_ADDR, 8'h11);
      cyc(8);
      chk({7'h00, po.ss_n}, 8'h01);
      rd_chk(STATUS_ADDR, 8'h88);
      wr_reg(STATUS_ADDR, 8'h08);
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      $display("test controller done");
      tx = 8'hc3;
      wr_reg(DATA_ADDR, 8'h5a);
      cyc(6);
      wr_reg(DATA_ADDR, 8'hff);
      wirq();
      chk(pr_rx, 8'h5a);
      rd_chk(STATUS_ADDR, 8'hc8);
      rd_chk(DATA_ADDR, 8'hc3);
      wr_reg(STATUS_ADDR, 8'h08);
      wr_reg(CTRL_ADDR, 8'h50);
      cyc(2);
      chk({7'h00, po.ss_oe}, 8'h00);
      $display("test collision done");
      wr_reg(STATUS_ADDR, 8'h00);
      wr_reg(CTRL_ADDR, 8'hd0);
      cyc(2);
      chk({7'h00, po.ss_oe}, 8'h00);
      i_peer.select(1'b0);
      wirq();
      rd_chk(STATUS_ADDR, 8'h10);
      rd_chk(CTRL_ADDR, 8'h80);
      i_peer.select(1'b1);
      cyc(4);
      rd_chk(STATUS_ADDR, 8'h10);
      wr_reg(IRQEN_ADDR, 8'h01);
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      $display("test mode fault done");
      wr_reg(IRQEN_ADDR, 8'h03);
      wr_reg(STATUS_ADDR, 8'h08);
      wr_reg(CTRL_ADDR, 8'hc0);
      cyc(2);
      chk({7'h00, po.ss_oe}, 8'h00);
      wr_reg(DATA_ADDR, 8'h96);
      sxfer(8'h69);
      chk(got, 8'h96);
      wirq();
      rd_chk(DATA_ADDR, 8'h69);
      // next byte arrives before software clears done
      sxfer(8'h42);
      cyc(4);
      rd_chk(STATUS_ADDR, 8'ha8);
      rd_chk(DATA_ADDR, 8'h69);
      wr_reg(STATUS_ADDR, 8'h08);
      sxfer(8'h24);
      wirq();
      rd_chk(DATA_ADDR, 8'h24);
      $display("test target done");
      results();
   end
endmodule : tb_spi_status_data_select
`default_nettype wire
